// File: port_read_pkg.sv
package port_read_pkg;

  // ****************************************************************
  // bus addressing and bit counting
  // ****************************************************************
  localparam logic [3:0] ADDR_HI = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int MSB = 7;

  // ****************************************************************
  // command byte selections and register defaults
  // ****************************************************************
  localparam logic [1:0] SEL_INPUT = 2'h0;
  localparam logic [1:0] SEL_OUTPUT = 2'h1;
  localparam logic [1:0] SEL_POLARITY = 2'h2;
  localparam logic [1:0] SEL_CONFIG = 2'h3;
  localparam logic [7:0] OUTPUT_RST = 8'hff;
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } state_t;

endpackage : port_read_pkg

// File: level_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser; the first stage feeds only the second
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : level_sync

// File: port_read.sv
`timescale 1ns/1ps

// Operation
// - capture port pins at the rising edge of a read address ack or a master ack; write acks capture nothing
// - keep sending selected register every acknowledged byte
// - stop ends transfer; last captured value stands
// - command zero selects the input port
// - selection holds until new command byte
// - nack reads until a command byte arrives
// - input port shows real pin levels; unwritable
module port_read (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  input wire logic [2:0] ADDR_PIN_I,
  input wire logic [7:0] PORT_PIN_I,
  output logic [7:0] IN_PORT_O,
  output logic BUSY_O
);

  // ****************************************************************
  // link clock side: pin snapshot on every rising bus clock
  // ****************************************************************
  // the snapshot is only read by the main clock after the synchronised
  // bus clock has risen, so it is stable for the whole high phase
  logic [7:0] snap_q;

  always_ff @(posedge SCL_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      snap_q <= port_read_pkg::BYTE_ZERO;
    else
      snap_q <= PORT_PIN_I;
  end

  // ****************************************************************
  // synchronisers and bus event decode
  // ****************************************************************
  logic [4:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic [2:0] addr_pin_s;
  logic scl_p_q;
  logic sda_p_q;

  level_sync #(.WIDTH(5)) u_sync (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .d_i({~SCL_I, ~SDA_I, ADDR_PIN_I}),
    .q_o(sync_q)
  );

  // bus lines pass inverted so a cleared synchroniser reads as an idle high bus:
  // no false clock or data edge right after reset
  assign scl_s = ~sync_q[4];
  assign sda_s = ~sync_q[3];
  assign addr_pin_s = sync_q[2:0];

  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else if (CE_I)
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ****************************************************************
  // registers and selection
  // ****************************************************************
  port_read_pkg::state_t state_q;
  port_read_pkg::state_t state_d;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] cmd_q;
  logic cmd_set_q;
  logic drv_q;
  logic [7:0] in_q;
  logic is_rd_q;
  wire byte_done = (cnt_q == port_read_pkg::BYTE_BITS);

  wire [1:0] sel = cmd_q[1:0];
  wire addr_hit = (sh_q[7:1] == {port_read_pkg::ADDR_HI, addr_pin_s});
  wire is_read = sh_q[0];
  // only the input port is live here; the other registers read their defaults
  wire [7:0] next_byte = (sel == port_read_pkg::SEL_INPUT) ? snap_q :
                         (sel == port_read_pkg::SEL_OUTPUT) ? port_read_pkg::OUTPUT_RST :
                         (sel == port_read_pkg::SEL_POLARITY) ? port_read_pkg::POLARITY_RST :
                         port_read_pkg::CONFIG_RST;
  wire [7:0] sh_in = {sh_q[6:0], sda_s};
  wire [7:0] sh_out = {sh_q[6:0], 1'b0};

  always_comb
  begin
    state_d = state_q;
    if (stop_ev)
      state_d = port_read_pkg::ST_IDLE;
    else if (start_ev)
      state_d = port_read_pkg::ST_ADDR;
    else
    begin
      case (state_q)
        port_read_pkg::ST_ADDR:
          if (scl_fall && byte_done)
          begin
            if (!addr_hit || (is_read && !cmd_set_q))
              state_d = port_read_pkg::ST_IDLE;
            else
              state_d = port_read_pkg::ST_ADDR_ACK;
          end
        port_read_pkg::ST_ADDR_ACK:
          if (scl_fall)
            state_d = is_rd_q ? port_read_pkg::ST_RDATA : port_read_pkg::ST_CMD;
        port_read_pkg::ST_CMD, port_read_pkg::ST_WDATA:
          if (scl_fall && byte_done)
            state_d = port_read_pkg::ST_WACK;
        port_read_pkg::ST_WACK:
          if (scl_fall)
            state_d = port_read_pkg::ST_WDATA;
        port_read_pkg::ST_RDATA:
          if (scl_fall && byte_done)
            state_d = port_read_pkg::ST_RACK;
        port_read_pkg::ST_RACK:
          if (scl_rise && sda_s)
            state_d = port_read_pkg::ST_IDLE;
          else if (scl_fall)
            state_d = port_read_pkg::ST_RDATA;
        default:
          state_d = port_read_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // datapath
  // ****************************************************************
  wire ack_edge = scl_rise && ((state_q == port_read_pkg::ST_ADDR_ACK && is_rd_q) ||
                               (state_q == port_read_pkg::ST_RACK && !sda_s));
  // a write address ack has nothing to send: its counter must restart at zero instead
  wire load_out = scl_fall && ((state_q == port_read_pkg::ST_ADDR_ACK && is_rd_q) ||
                               state_q == port_read_pkg::ST_RACK);
  wire in_rx = (state_q == port_read_pkg::ST_ADDR || state_q == port_read_pkg::ST_CMD ||
                state_q == port_read_pkg::ST_WDATA);

  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state_q <= port_read_pkg::ST_IDLE;
      cnt_q <= port_read_pkg::CNT_ZERO;
      sh_q <= port_read_pkg::BYTE_ZERO;
      is_rd_q <= 1'b0;
      in_q <= port_read_pkg::BYTE_ZERO;
    end
    else if (CE_I)
    begin
      state_q <= state_d;
      if (start_ev)
        cnt_q <= port_read_pkg::CNT_ZERO;
      else if (scl_rise && in_rx && !byte_done)
      begin
        sh_q <= sh_in;
        cnt_q <= cnt_q + port_read_pkg::CNT_ONE;
      end
      else if (ack_edge)
      begin
        in_q <= snap_q;
        sh_q <= next_byte;
      end
      else if (load_out)
      begin
        sh_q <= sh_out;
        cnt_q <= port_read_pkg::CNT_ONE;
      end
      else if (scl_fall && state_q == port_read_pkg::ST_RDATA && !byte_done)
      begin
        sh_q <= sh_out;
        cnt_q <= cnt_q + port_read_pkg::CNT_ONE;
      end
      else if (scl_fall && (state_q == port_read_pkg::ST_WACK || state_q == port_read_pkg::ST_ADDR_ACK))
        cnt_q <= port_read_pkg::CNT_ZERO;
      if (scl_fall && state_q == port_read_pkg::ST_ADDR && byte_done)
        is_rd_q <= is_read;
    end
  end

  // command byte survives stops and restarts until rewritten
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cmd_q <= port_read_pkg::BYTE_ZERO;
      cmd_set_q <= 1'b0;
    end
    else if (CE_I && !start_ev && !stop_ev && scl_fall && byte_done && state_q == port_read_pkg::ST_CMD)
    begin
      cmd_q <= sh_q;
      cmd_set_q <= 1'b1;
    end
  end

  // ****************************************************************
  // data line drive: open drain, low only
  // ****************************************************************
  logic drv_d;

  always_comb
  begin
    drv_d = drv_q;
    if (state_d == port_read_pkg::ST_IDLE || start_ev)
      drv_d = 1'b0;
    else if (scl_fall)
    begin
      case (state_q)
        port_read_pkg::ST_ADDR, port_read_pkg::ST_CMD, port_read_pkg::ST_WDATA:
          drv_d = byte_done;
        port_read_pkg::ST_ADDR_ACK:
          drv_d = is_rd_q & ~sh_q[port_read_pkg::MSB];
        port_read_pkg::ST_RACK:
          drv_d = ~sh_q[port_read_pkg::MSB];
        port_read_pkg::ST_RDATA:
          drv_d = ~byte_done & ~sh_q[port_read_pkg::MSB];
        default:
          drv_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      drv_q <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_N_O <= 1'b1;
      IN_PORT_O <= port_read_pkg::BYTE_ZERO;
      BUSY_O <= 1'b0;
    end
    else if (CE_I)
    begin
      drv_q <= drv_d;
      SDA_O <= 1'b0;
      SDA_OE_N_O <= ~drv_d;
      IN_PORT_O <= in_q;
      BUSY_O <= (state_q != port_read_pkg::ST_IDLE);
    end
  end

endmodule : port_read

// File: i2c_master_model.sv
`timescale 1ns/1ps
// ***
// bus master model
// ***
module i2c_master_model (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // scl stands high between frames; low phase outlasts the slave's 2-3 cycle answer
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic clk_bit(input logic b, output logic r);
    #10 sda_o = b;
    #40 scl_o = 1'b1;
    #28 r = sda_i;
    #2 scl_o = 1'b0;
  endtask : clk_bit
  task automatic start();
    #10 sda_o = 1'b1;
    #10 scl_o = 1'b1;
    #20 sda_o = 1'b0;
    #20 scl_o = 1'b0;
  endtask : start
  task automatic stop();
    #10 sda_o = 1'b0;
    #40 scl_o = 1'b1;
    #30 sda_o = 1'b1;
    #20;
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, ack_n);
  endtask : wr_byte
  task automatic rd_byte(input logic ack_n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(ack_n, r);
  endtask : rd_byte
endmodule : i2c_master_model

// File: port_read_monitor.sv
`timescale 1ns/1ps
// ***
// bus checker
// ***
module port_read_monitor (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  input wire logic [7:0] PORT_PIN_I,
  input wire logic [7:0] IN_PORT_O,
  input wire logic BUSY_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  sequence idle_s;
    !BUSY_O ##1 !BUSY_O;
  endsequence
  sequence start_s;
    SCL_I && $fell(SDA_I);
  endsequence
  sequence stop_s;
    SCL_I && $rose(SDA_I);
  endsequence
  AST_OD: assert property (!SDA_O) else $error("sda out high");
  AST_IDLE: assert property (idle_s |-> SDA_OE_N_O) else $error("drive when idle");
  AST_HOLD: assert property (idle_s |-> $stable(IN_PORT_O)) else $error("port moved");
  AST_CAP: assert property ($changed(IN_PORT_O) |-> BUSY_O && IN_PORT_O == $past(PORT_PIN_I, 3)) else $error("cap");
  AST_START: assert property (start_s |-> ##[1:5] BUSY_O) else $error("no busy");
  AST_STOP: assert property (stop_s |-> ##[1:6] !BUSY_O) else $error("busy after stop");
  AST_SCLH: assert property ($rose(SCL_I) |=> $stable(SDA_OE_N_O) [*2]) else $error("sda moved");
  AST_DRV: assert property ($fell(SDA_OE_N_O) |-> BUSY_O && !SCL_I) else $error("bad drive");
endmodule : port_read_monitor
bind port_read port_read_monitor mon_u (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .PORT_PIN_I(PORT_PIN_I), .IN_PORT_O(IN_PORT_O), .BUSY_O(BUSY_O));

// File: port_read_tb_top.sv
`timescale 1ns/1ps
// ***
// read path bench
// ***
module port_read_tb_top;
  logic mclk, arst_n, ce, scl, m_sda, sda_o, oe_n, busy, a;
  logic [2:0] adr;
  logic [7:0] pins, in_port, r;
  logic [31:0] seed_q;
  int n_fail, total_checks;
  // open drain: a released line floats to the pull-up
  wire logic sda = m_sda & (oe_n | sda_o);
  port_read dut_u (.MCLK_I(mclk), .ARST_N_I(arst_n), .CE_I(ce), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_N_O(oe_n), .ADDR_PIN_I(adr), .PORT_PIN_I(pins), .IN_PORT_O(in_port), .BUSY_O(busy));
  i2c_master_model m_u (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [7:0] exp_rd(input logic [1:0] s, input logic [7:0] p);
    if (s == port_read_pkg::SEL_INPUT) return p;
    if (s == port_read_pkg::SEL_OUTPUT) return port_read_pkg::OUTPUT_RST;
    return (s == port_read_pkg::SEL_POLARITY) ? port_read_pkg::POLARITY_RST : port_read_pkg::CONFIG_RST;
  endfunction : exp_rd
  function automatic logic [7:0] ab(input logic [2:0] ad, input logic rw);
    return {port_read_pkg::ADDR_HI, ad, rw};
  endfunction : ab
  function automatic logic [7:0] rnd8();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q[7:0];
  endfunction : rnd8
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic set_in(input logic [7:0] p, input logic [2:0] ad);
    @(posedge mclk);
    pins <= p;
    adr <= ad;
    @(posedge mclk);
    // bus events then fall between clock edges, as on an unrelated link clock
    #3;
  endtask : set_in
  task automatic wr_cmd(input logic [7:0] c, input logic [2:0] ad, input logic exp_n);
    m_u.start();
    m_u.wr_byte(ab(ad, 1'b0), a);
    chk1(a, exp_n);
    if (exp_n === 1'b0)
    begin
      m_u.wr_byte(c, a);
      chk1(a, 1'b0);
      m_u.wr_byte((c[1:0] == port_read_pkg::SEL_CONFIG) ? port_read_pkg::BYTE_ZERO : c ^ 8'h5a, a);
      chk1(a, 1'b0);
    end
    m_u.stop();
  endtask : wr_cmd
  // pins for byte k+1 change just before byte k shifts, after its capture, so a late capture shows up
  task automatic rd_frame(input logic [1:0] s, input int n);
    logic [7:0] p [0:4];
    logic [7:0] b;
    for (int k = 0; k < 5; k++) p[k] = rnd8();
    set_in(p[0], adr);
    m_u.start();
    m_u.wr_byte(ab(adr, 1'b1), a);
    chk1(a, 1'b0);
    for (int k = 0; k < n; k++)
    begin
      if (k < n - 1) set_in(p[k + 1], adr);
      m_u.rd_byte(k == n - 1, b);
      chk8(b, exp_rd(s, p[k]));
    end
    m_u.stop();
    repeat (8) @(posedge mclk);
    chk1(busy, 1'b0);
    if (s == port_read_pkg::SEL_INPUT) chk8(in_port, p[n - 1]);
  endtask : rd_frame
  task automatic end_of_test();
    $display("checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    #900000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    ce = 1'b1;
    arst_n = 1'b0;
    pins = 8'h00;
    adr = 3'h5;
    seed_q = 32'h00017be6;
    n_fail = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #3;
    m_u.start();
    m_u.wr_byte(ab(adr, 1'b1), a);
    m_u.stop();
    chk1(a, 1'b1);
    wr_cmd(8'h00, adr ^ 3'h1, 1'b1);
    for (int s = 1; s < 5; s++)
    begin
      r = rnd8();
      set_in(pins, r[2:0]);
      wr_cmd({6'h00, 2'(s)}, r[2:0], 1'b0);
      rd_frame(2'(s), 2);
    end
    rd_frame(2'h0, 5);
    rd_frame(2'h0, 1);
    end_of_test();
  end
endmodule : port_read_tb_top
